// File: hw/gdcr_regs.sv
// Configuration and status register bank of the three-phase gate driver
`timescale 1ns/100ps
`default_nettype none
// Function
// - Ready mask 0x07: standby, overtemp, undervolt enables
// - Overtemp reaches ready only when enabled
// - Protected fault mask 0x08, enables default set
// - All-ones write to 0x09 clears latched faults
// - Commands run only on all-ones byte
// - Command registers always read 0xFF
// - Protected standby register 0x0A, request bit 0
// - Lock 0x0B: low nibble must complement high nibble
// - Locked protected registers ignore writes
// - Unlocked state forces all gate outputs low
// - Protected register reset 0x0C restores defaults, keeps flag
// - Status bit 7 shows lock state
// - Status bit 3 shows reset occurred
// - Status bit 2 shows drain-source trip
// - Status bit 1 shows thermal shutdown
// - Status bit 0 shows supply undervoltage
// - Registers use plain I2C register transactions
// - Only critical registers are write protected
// - Target answers only at address 1000111
// - Reset and trip latch; others self-clear
// - Fault output always reports register reset
module gdcr_regs #(
    parameter int GATE_COUNT = 6
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire gdcr_pkg::gdcr_cond_s COND,
    input wire logic [GATE_COUNT-1:0] GATE_IN,
    output logic [GATE_COUNT-1:0] GATE_OUT,
    output logic READY_OUT,
    output logic READY_OE,
    output logic FAULT_OUT,
    output logic FAULT_OE,
    output logic STANDBY_REQ
);
    import gdcr_pkg::*;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    gdcr_wr_s wr;
    logic [7:0] rd_addr, rd_data, status;
    logic [7:0] ready_mask, fault_mask, standby_reg, lock_reg;
    logic [7:0] next_ready_mask, next_fault_mask, next_standby_reg, next_lock_reg;
    logic reset_flag, ds_flag, next_reset_flag, next_ds_flag;
    logic unlocked, clear_cmd, regrst_cmd;
    logic next_ready_oe, next_fault_oe, next_standby;
    logic [GATE_COUNT-1:0] next_gate;

    // Keeps fixed bits at their default so they read back unchanged
    function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] wmask,
                                          input logic [7:0] rst);
        masked = (data & wmask) | (rst & ~wmask);
    endfunction

    function automatic logic cmd_hit(input gdcr_wr_s w, input logic [7:0] addr);
        cmd_hit = w.wr && (w.addr == addr) && (w.data == ALL_ONES);
    endfunction

    gdcr_i2c_target u_i2c (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .sda_out(SDA_OUT),
        .sda_oe(SDA_OE),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    assign unlocked = (lock_reg[3:0] == ~lock_reg[7:4]);
    assign clear_cmd = cmd_hit(wr, ADDR_CLEAR);
    assign regrst_cmd = cmd_hit(wr, ADDR_RESET) && unlocked;

    always_comb begin
        next_ready_mask = ready_mask;
        next_fault_mask = fault_mask;
        next_standby_reg = standby_reg;
        next_lock_reg = lock_reg;
        if (regrst_cmd) begin
            next_ready_mask = READY_RST;
            next_fault_mask = FAULT_RST;
            next_standby_reg = LOW_POWER_REQUEST_RST;
            next_lock_reg = LOCK_RST;
        end else if (wr.wr) begin
            case (wr.addr)
                ADDR_READY: begin
                    next_ready_mask = masked(wr.data, READY_WMASK, READY_RST);
                end
                ADDR_FAULT: begin
                    if (unlocked) begin
                        next_fault_mask = masked(wr.data, FAULT_WMASK, FAULT_RST);
                    end
                end
                ADDR_LOW_POWER_REQUEST: begin
                    if (unlocked) begin
                        next_standby_reg = masked(wr.data, LOW_POWER_REQUEST_WMASK, LOW_POWER_REQUEST_RST);
                    end
                end
                ADDR_LOCK: begin
                    next_lock_reg = wr.data;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ready_mask <= READY_RST;
            fault_mask <= FAULT_RST;
            standby_reg <= LOW_POWER_REQUEST_RST;
            lock_reg <= LOCK_RST;
        end else begin
            ready_mask <= next_ready_mask;
            fault_mask <= next_fault_mask;
            standby_reg <= next_standby_reg;
            lock_reg <= next_lock_reg;
        end
    end

    // A trip in the clearing cycle survives the clear
    always_comb begin
        next_reset_flag = reset_flag;
        next_ds_flag = ds_flag;
        if (clear_cmd) begin
            next_reset_flag = 1'b0;
            next_ds_flag = 1'b0;
        end
        if (COND.ds_trip) begin
            next_ds_flag = 1'b1;
        end
    end

    // Power-up counts as a register reset, so the flag starts set
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            reset_flag <= 1'b1;
            ds_flag <= 1'b0;
        end else begin
            reset_flag <= next_reset_flag;
            ds_flag <= next_ds_flag;
        end
    end

    always_comb begin
        status = '0;
        status[ST_LOCK_BIT] = ~unlocked;
        status[ST_RST_BIT] = reset_flag;
        status[ST_DS_BIT] = ds_flag;
        status[ST_OT_BIT] = COND.overtemp;
        status[ST_UV_BIT] = COND.undervolt;
        case (rd_addr)
            ADDR_READY: rd_data = ready_mask;
            ADDR_FAULT: rd_data = fault_mask;
            ADDR_CLEAR, ADDR_RESET: rd_data = CMD_READ_VALUE;
            ADDR_LOW_POWER_REQUEST: rd_data = standby_reg;
            ADDR_LOCK: rd_data = lock_reg;
            ADDR_STATUS: rd_data = status;
            default: rd_data = UNMAPPED_READ;
        endcase
    end

    always_comb begin
        next_ready_oe = (standby_reg[LOW_POWER_REQUEST_REQ_BIT] & ready_mask[RDY_LOW_POWER_REQUEST_BIT])
            | (COND.overtemp & ready_mask[RDY_OT_BIT])
            | (COND.undervolt & ready_mask[RDY_UV_BIT]);
        next_fault_oe = reset_flag
            | (ds_flag & fault_mask[FLT_DS_BIT])
            | (COND.overtemp & fault_mask[FLT_OT_BIT])
            | (COND.undervolt & fault_mask[FLT_UV_BIT]);
        // Unlocking for reconfiguration parks the power stage
        next_gate = unlocked ? '0 : GATE_IN;
        next_standby = standby_reg[LOW_POWER_REQUEST_REQ_BIT];
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            READY_OE <= 1'b1;
            FAULT_OE <= 1'b1;
            READY_OUT <= 1'b0;
            FAULT_OUT <= 1'b0;
            GATE_OUT <= '0;
            STANDBY_REQ <= 1'b0;
        end else begin
            READY_OE <= next_ready_oe;
            FAULT_OE <= next_fault_oe;
            READY_OUT <= 1'b0;
            FAULT_OUT <= 1'b0;
            GATE_OUT <= next_gate;
            STANDBY_REQ <= next_standby;
        end
    end

    property p_reset_defaults;
        $past(SYS_RST) |-> ready_mask == READY_RST && fault_mask == FAULT_RST
            && standby_reg == LOW_POWER_REQUEST_RST && lock_reg == LOCK_RST && reset_flag;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset values");

    property p_overtemp_masked;
        COND.overtemp && !ready_mask[RDY_OT_BIT] && !COND.undervolt
            && !standby_reg[LOW_POWER_REQUEST_REQ_BIT] |=> !READY_OE;
    endproperty
    a_overtemp_masked: assert property (p_overtemp_masked) else $error("ready not masked");

    property p_overtemp_shown;
        COND.overtemp && ready_mask[RDY_OT_BIT] |=> READY_OE;
    endproperty
    a_overtemp_shown: assert property (p_overtemp_shown) else $error("ready missing overtemp");

    property p_clear_cmd;
        wr.wr && wr.addr == ADDR_CLEAR && wr.data == ALL_ONES && !COND.ds_trip
            |=> !ds_flag && !reset_flag ##1 !FAULT_OE || COND.overtemp || COND.undervolt || ds_flag;
    endproperty
    a_clear_cmd: assert property (p_clear_cmd) else $error("clear not executed");

    property p_clear_reject;
        wr.wr && wr.addr == ADDR_CLEAR && wr.data != ALL_ONES |=> $stable(reset_flag);
    endproperty
    a_clear_reject: assert property (p_clear_reject) else $error("bad clear accepted");

    property p_cmd_read;
        rd_addr == ADDR_CLEAR || rd_addr == ADDR_RESET |-> rd_data == CMD_READ_VALUE;
    endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("command read not FF");

    property p_locked_write;
        wr.wr && !unlocked && (wr.addr == ADDR_FAULT || wr.addr == ADDR_LOW_POWER_REQUEST)
            |=> $stable(fault_mask) && $stable(standby_reg);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("locked write landed");

    property p_gate_forced;
        unlocked |=> GATE_OUT == '0;
    endproperty
    a_gate_forced: assert property (p_gate_forced) else $error("gates not forced low");

    property p_regrst;
        regrst_cmd |=> lock_reg == LOCK_RST && fault_mask == FAULT_RST
            && reset_flag == $past(reset_flag);
    endproperty
    a_regrst: assert property (p_regrst) else $error("register reset wrong");

    property p_lock_status;
        rd_addr == ADDR_STATUS |-> rd_data[ST_LOCK_BIT] == !unlocked;
    endproperty
    a_lock_status: assert property (p_lock_status) else $error("lock status wrong");

    property p_ds_latched;
        ds_flag && !clear_cmd |=> ds_flag;
    endproperty
    a_ds_latched: assert property (p_ds_latched) else $error("trip not latched");

    property p_reset_unmasked;
        reset_flag |=> FAULT_OE;
    endproperty
    a_reset_unmasked: assert property (p_reset_unmasked) else $error("reset not on fault");

    property p_ready_fixed;
        (ready_mask & ~READY_WMASK) == (READY_RST & ~READY_WMASK);
    endproperty
    a_ready_fixed: assert property (p_ready_fixed) else $error("ready fixed bits");

    property p_fault_fixed;
        (fault_mask & ~FAULT_WMASK) == (FAULT_RST & ~FAULT_WMASK);
    endproperty
    a_fault_fixed: assert property (p_fault_fixed) else $error("fault fixed bits");

    property p_standby_pin;
        standby_reg[LOW_POWER_REQUEST_REQ_BIT] |=> STANDBY_REQ;
    endproperty
    a_standby_pin: assert property (p_standby_pin) else $error("standby pin low");

    property p_lock_open;
        wr.wr && wr.addr == ADDR_LOCK |=> lock_reg == $past(wr.data);
    endproperty
    a_lock_open: assert property (p_lock_open) else $error("lock write lost");

    property p_ds_set;
        COND.ds_trip |=> ds_flag;
    endproperty
    a_ds_set: assert property (p_ds_set) else $error("trip not captured");

    property p_live_status;
        rd_addr == ADDR_STATUS |-> rd_data[ST_OT_BIT] == COND.overtemp
            && rd_data[ST_UV_BIT] == COND.undervolt;
    endproperty
    a_live_status: assert property (p_live_status) else $error("live status wrong");

    property p_gate_follow;
        !unlocked |=> GATE_OUT == $past(GATE_IN);
    endproperty
    a_gate_follow: assert property (p_gate_follow) else $error("gates not following");

    property p_regrst_rest;
        regrst_cmd |=> ready_mask == READY_RST && standby_reg == LOW_POWER_REQUEST_RST;
    endproperty
    a_regrst_rest: assert property (p_regrst_rest) else $error("register reset partial");

    c_unlock: cover property (!unlocked ##1 unlocked);
    c_clear: cover property (clear_cmd && ds_flag);
    c_regrst: cover property (regrst_cmd);
    c_status_read: cover property (rd_addr == ADDR_STATUS && SDA_OE);
    c_trip: cover property (COND.ds_trip ##1 ds_flag);
endmodule
`default_nettype wire

// File: hw/gdcr_pkg.sv
// Shared constants and types of the gate driver configuration register bank
package gdcr_pkg;
    localparam logic [6:0] I2C_DEV_ADDR = 7'h47;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    localparam logic [7:0] ADDR_READY = 8'h07;
    localparam logic [7:0] ADDR_FAULT = 8'h08;
    localparam logic [7:0] ADDR_CLEAR = 8'h09;
    localparam logic [7:0] ADDR_LOW_POWER_REQUEST = 8'h0A;
    localparam logic [7:0] ADDR_LOCK = 8'h0B;
    localparam logic [7:0] ADDR_RESET = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h80;

    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] CMD_READ_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam logic [7:0] READY_RST = 8'h09;
    localparam logic [7:0] READY_WMASK = 8'h0B;
    localparam logic [7:0] FAULT_RST = 8'h7F;
    localparam logic [7:0] FAULT_WMASK = 8'h07;
    localparam logic [7:0] LOW_POWER_REQUEST_RST = 8'h00;
    localparam logic [7:0] LOW_POWER_REQUEST_WMASK = 8'h01;
    localparam logic [7:0] LOCK_RST = 8'h00;

    localparam int RDY_LOW_POWER_REQUEST_BIT = 3;
    localparam int RDY_OT_BIT = 1;
    localparam int RDY_UV_BIT = 0;
    localparam int FLT_DS_BIT = 2;
    localparam int FLT_OT_BIT = 1;
    localparam int FLT_UV_BIT = 0;
    localparam int LOW_POWER_REQUEST_REQ_BIT = 0;
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_RST_BIT = 3;
    localparam int ST_DS_BIT = 2;
    localparam int ST_OT_BIT = 1;
    localparam int ST_UV_BIT = 0;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } gdcr_wr_s;

    typedef struct packed {
        logic ds_trip;
        logic overtemp;
        logic undervolt;
    } gdcr_cond_s;
endpackage

// File: hw/gdcr_i2c_target.sv
// I2C target engine: one register pointer byte, then data bytes
`timescale 1ns/100ps
`default_nettype none
module gdcr_i2c_target (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output gdcr_pkg::gdcr_wr_s wr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import gdcr_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_A = 4'h3,
        ST_REG = 4'h2,
        ST_ACK_R = 4'h6,
        ST_WDATA = 4'h7,
        ST_ACK_W = 4'h5,
        ST_RDATA = 4'h4,
        ST_RACK = 4'hC
    } gdcr_i2c_state_e;

    gdcr_i2c_state_e state, next_state;
    logic [7:0] shift, next_shift;
    logic [2:0] cnt, next_cnt;
    logic got, next_got, rw, next_rw, nack, next_nack, next_oe;
    logic scl_q, sda_q;
    logic [7:0] next_ptr;
    gdcr_wr_s next_wr;
    logic scl_rise, scl_fall, start, stop;

    always_comb begin
        scl_rise = scl_in & ~scl_q;
        scl_fall = ~scl_in & scl_q;
        start = scl_in & scl_q & sda_q & ~sda_in;
        stop = scl_in & scl_q & ~sda_q & sda_in;
        next_state = state;
        next_shift = shift;
        next_cnt = cnt;
        next_got = got;
        next_rw = rw;
        next_nack = nack;
        next_oe = sda_oe;
        next_ptr = rd_addr;
        next_wr = '{wr: 1'b0, addr: rd_addr, data: shift};
        if (start) begin
            next_state = ST_ADDR;
            next_cnt = '0;
            next_got = 1'b0;
            next_oe = 1'b0;
        end else if (stop) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise && !got) begin
                        next_shift = {shift[6:0], sda_in};
                        next_cnt = cnt + 3'h1;
                        next_got = (cnt == BYTE_LAST_BIT);
                    end else if (scl_fall && got) begin
                        next_got = 1'b0;
                        next_oe = 1'b1;
                        case (state)
                            ST_ADDR: begin
                                // Foreign addresses get no acknowledge
                                if (shift[7:1] == I2C_DEV_ADDR) begin
                                    next_state = ST_ACK_A;
                                    next_rw = shift[0];
                                end else begin
                                    next_state = ST_IDLE;
                                    next_oe = 1'b0;
                                end
                            end
                            ST_REG: begin
                                next_ptr = shift;
                                next_state = ST_ACK_R;
                            end
                            default: begin
                                next_wr.wr = 1'b1;
                                next_state = ST_ACK_W;
                            end
                        endcase
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        next_cnt = '0;
                        if (rw) begin
                            next_state = ST_RDATA;
                            next_shift = rd_data;
                            next_oe = ~rd_data[7];
                        end else begin
                            next_state = ST_REG;
                            next_oe = 1'b0;
                        end
                    end
                end
                ST_ACK_R, ST_ACK_W: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_state = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == BYTE_LAST_BIT) begin
                            next_state = ST_RACK;
                            next_oe = 1'b0;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_oe = ~shift[6];
                            next_cnt = cnt + 3'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_nack = sda_in;
                    end else if (scl_fall) begin
                        next_cnt = '0;
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_state = ST_RDATA;
                            next_shift = rd_data;
                            next_oe = ~rd_data[7];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            shift <= '0;
            cnt <= '0;
            got <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rd_addr <= '0;
            wr <= '0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            cnt <= next_cnt;
            got <= next_got;
            rw <= next_rw;
            nack <= next_nack;
            sda_oe <= next_oe;
            sda_out <= 1'b0;
            scl_q <= scl_in;
            sda_q <= sda_in;
            rd_addr <= next_ptr;
            wr <= next_wr;
        end
    end
endmodule
`default_nettype wire

// File: verif/gdcr_host_model.sv
// I2C host model standing in for the companion controller
`timescale 1ns/100ps
`default_nettype none
module gdcr_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_oe,
    output logic rd_valid,
    output logic [7:0] rd_byte
);
    import gdcr_pkg::*;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        rd_valid = 1'b0;
        rd_byte = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Four clocks a phase stays clear of the three-clock minimum
    task automatic put_bit(input logic b);
        sda_oe = ~b;
        tick(4);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        sda_oe = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(2);
        b = sda_line;
        tick(2);
        scl = 1'b0;
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        sda_oe = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b0;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] d, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ok = ok & ~a;
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
                             input logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        put_byte({dev, 1'b0}, ok);
        put_byte(ra, ok);
        put_byte(d, ok);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ra, output logic ok);
        logic [7:0] d;
        ok = 1'b1;
        start();
        put_byte({I2C_DEV_ADDR, 1'b0}, ok);
        put_byte(ra, ok);
        start();
        put_byte({I2C_DEV_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
        rd_byte = d;
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/gate_driver_config_regs_tb.sv
// Self-checking bench for the gate driver register bank
`timescale 1ns/100ps
`default_nettype none
module gate_driver_config_regs_tb;
    import gdcr_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, host_oe, rd_valid, sda_out, sda_oe, ready_oe, fault_oe, low_power_request, ok;
    logic ready_out, fault_out;
    logic [7:0] rd_byte;
    logic [5:0] gate_in = 6'h00;
    logic [5:0] gate_out;
    gdcr_cond_s cond = 3'h0;
    wire logic sda_line;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    // Pull-up on the data wire, either side may pull low
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_oe;
    always #5 clk_sys = ~clk_sys;
    gdcr_regs #(.GATE_COUNT(6)) i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .COND(cond),
        .GATE_IN(gate_in), .GATE_OUT(gate_out), .READY_OUT(ready_out), .READY_OE(ready_oe),
        .FAULT_OUT(fault_out), .FAULT_OE(fault_oe), .STANDBY_REQ(low_power_request));
    gdcr_host_model i_host (.clk(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_oe(host_oe), .rd_valid(rd_valid), .rd_byte(rd_byte));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        exp_q.push_back(exp);
        i_host.read_reg(ra, ok);
        check({7'h00, ok}, 8'h01, "read ack");
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        i_host.write_reg(I2C_DEV_ADDR, ra, d, ok);
        check({7'h00, ok}, 8'h01, "write ack");
    endtask
    task automatic pin(input logic got, input logic exp, input string what);
        check({7'h00, got}, {7'h00, exp}, what);
    endtask
    // Results are matched against notes in the order they were made
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("mismatch at %0t: unexpected read", $time);
            end else begin
                check(rd_byte, exp_q.pop_front(), "read data");
            end
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            $display("mismatch at %0t: timeout", $time);
            complete_run();
        end
    end
    initial begin
        logic [7:0] v;
        void'($urandom(32'h615C));
        step(20);
        sys_rst = 1'b0;
        step(2);
        pin(fault_oe, 1'b1, "fault after reset");
        rd(ADDR_READY, 8'h09);
        rd(ADDR_FAULT, 8'h7F);
        rd(ADDR_LOW_POWER_REQUEST, 8'h00);
        rd(ADDR_LOCK, 8'h00);
        rd(ADDR_CLEAR, 8'hFF);
        rd(ADDR_RESET, 8'hFF);
        rd(ADDR_STATUS, 8'h88);
        rd(8'h05, 8'h00);
        $display("test reset values done");
        wr(ADDR_FAULT, 8'h00);
        wr(ADDR_LOW_POWER_REQUEST, 8'h01);
        wr(ADDR_READY, 8'hF6);
        wr(ADDR_RESET, 8'hFF);
        rd(ADDR_FAULT, 8'h7F);
        rd(ADDR_LOW_POWER_REQUEST, 8'h00);
        rd(ADDR_READY, 8'h02);
        pin(low_power_request, 1'b0, "standby locked");
        $display("test locked writes done");
        v = 8'($urandom_range(254, 0));
        wr(ADDR_CLEAR, v);
        rd(ADDR_STATUS, 8'h88);
        wr(ADDR_CLEAR, 8'hFF);
        rd(ADDR_STATUS, 8'h80);
        pin(fault_oe, 1'b0, "fault cleared");
        cond.ds_trip = 1'b1;
        step(1);
        cond.ds_trip = 1'b0;
        step(3);
        pin(fault_oe, 1'b1, "trip latched");
        pin(ready_out | fault_out, 1'b0, "open drain level");
        rd(ADDR_STATUS, 8'h84);
        wr(ADDR_CLEAR, 8'hFF);
        pin(fault_oe, 1'b0, "trip cleared");
        $display("test fault clear done");
        wr(ADDR_READY, 8'h09);
        cond.overtemp = 1'b1;
        step(3);
        pin(ready_oe, 1'b0, "overtemp masked");
        pin(fault_oe, 1'b1, "overtemp fault");
        rd(ADDR_STATUS, 8'h82);
        wr(ADDR_READY, 8'h02);
        pin(ready_oe, 1'b1, "overtemp ready");
        cond = 3'h1;
        step(3);
        pin(ready_oe, 1'b0, "undervolt masked");
        pin(fault_oe, 1'b1, "undervolt fault");
        rd(ADDR_STATUS, 8'h81);
        wr(ADDR_READY, 8'h0B);
        pin(ready_oe, 1'b1, "undervolt ready");
        cond = 3'h0;
        step(3);
        pin(ready_oe, 1'b0, "ready idle");
        $display("test live conditions done");
        wr(ADDR_LOCK, 8'h5A);
        rd(ADDR_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            gate_in = 6'($urandom_range(63, 1));
            step(2);
            pin(|gate_out, 1'b0, "gates forced low");
        end
        wr(ADDR_FAULT, 8'h00);
        rd(ADDR_FAULT, 8'h78);
        wr(ADDR_LOW_POWER_REQUEST, 8'hFF);
        rd(ADDR_LOW_POWER_REQUEST, 8'h01);
        pin(low_power_request, 1'b1, "standby request");
        pin(ready_oe, 1'b1, "standby ready");
        wr(ADDR_RESET, 8'($urandom_range(254, 0)));
        rd(ADDR_LOW_POWER_REQUEST, 8'h01);
        wr(ADDR_RESET, 8'hFF);
        rd(ADDR_READY, 8'h09);
        rd(ADDR_FAULT, 8'h7F);
        rd(ADDR_LOW_POWER_REQUEST, 8'h00);
        rd(ADDR_LOCK, 8'h00);
        rd(ADDR_STATUS, 8'h80);
        wr(ADDR_LOCK, 8'hA4);
        rd(ADDR_STATUS, 8'h80);
        v = {2'h0, 6'($urandom_range(63, 1))};
        gate_in = v[5:0];
        step(2);
        check({2'h0, gate_out}, v, "gates follow");
        $display("test lock and register reset done");
        i_host.write_reg(7'h46, ADDR_READY, 8'h00, ok);
        pin(ok, 1'b0, "foreign address");
        rd(ADDR_READY, 8'h09);
        $display("test device address done");
        step(4);
        check(8'(exp_q.size()), 8'h00, "reads left");
        complete_run();
    end
endmodule
`default_nettype wire
